// ---- pkg/drsm_pkg.sv ----
// Package for the disturbance record directory page.
// Assumes one clock domain and a serial-bus front end that decodes frames.
`default_nettype none
package drsm_pkg;

  // ***********************************
  // Page map and request codes
  // ***********************************
  localparam logic [15:0] DIR_ADDR = 16'h3d00;
  localparam logic [7:0] FUNC_READ_HOLD = 8'h03;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam int unsigned ENTRIES = 5;
  localparam int unsigned ENTRY_WORDS = 7;
  localparam logic [5:0] LAST_WORD = 6'h23;
  localparam logic [2:0] ENTRY_WORDS_W = 3'h7;
  localparam logic [2:0] ENTRIES_W = 3'h5;

  // ***********************************
  // Field codes and limits
  // ***********************************
  localparam logic [2:0] ORIGIN_MIN = 3'h1;
  localparam logic [2:0] ORIGIN_MAX = 3'h4;
  localparam logic [15:0] NUM_MIN = 16'h0001;
  localparam logic [15:0] ACK_SET = 16'h0001;
  localparam logic [31:0] EPOCH_1994_S = 32'h2d24_bd00;
  localparam logic [6:0] CHAR_MIN = 7'h20;
  localparam logic [7:0] CHAR_SUBST = 8'h20;
  localparam logic [15:0] INPUT_MASK = 16'h003f;
  localparam logic [15:0] CUR_DIS_MASK = 16'h0fff;
  localparam logic [15:0] FUNC_DIS_MASK = 16'h01ff;
  localparam logic [15:0] CONFIG_MAX = 16'h0004;
  localparam logic [15:0] VER_LETTER_BASE = 16'h000a;
  localparam logic [15:0] VER_DIGIT_SCALE = 16'h000a;

  // ***********************************
  // Types
  // ***********************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STREAM = 2'b01,
    ST_EXC = 2'b10
  } drsm_state_t;

  typedef struct packed {
    logic [15:0] number;
    logic [31:0] unix_s;
    logic [31:0] millis;
    logic [2:0] cause;
  } drsm_rec_in_t;

  typedef struct packed {
    logic [15:0] number;
    logic [31:0] seconds;
    logic [31:0] millis;
    logic [15:0] origin;
    logic [15:0] ack;
  } drsm_rec_t;

  typedef struct packed {
    logic [15:0] input_status;
    logic [15:0] current_prot_disable;
    logic [15:0] function_disable;
    logic [15:0] firmware_version;
    logic [15:0] hardware_version;
    logic [15:0] prot_configuration;
    logic [15:0] char_pair;
  } drsm_fmt_t;

  // Bytes below 20h or above 7Fh become a space
  function automatic logic [7:0] drsm_char(input logic [7:0] c);
    drsm_char = (c[7] == 1'b0 && c[6:0] >= CHAR_MIN) ? c : CHAR_SUBST;
  endfunction : drsm_char

endpackage : drsm_pkg
`default_nettype wire

// ---- core/drsm_directory.sv ----
// Read-only disturbance record directory page with the shared word formats.
// Assumes a frame decoder hands in one request at a time, synchronous to core_clk.
//
// Contract
// - Only function 03 at 3D00h returns directory
// - Word one holds stored record count
// - Seven words per entry, fixed field order
// - Dates: seconds double-word, then milliseconds double-word
// - Origin codes one to four by cause
// - Plain numeric fields stay within 1..65535
// - Text word packs two printable characters (code also passes 7Fh through unchanged)
// - Inputs one to six on bits 0-5
// - Current protection disable bits 0-11 only
// - Function disable bits 0-8 only
// - Firmware version is major digit, letter digit
// - Configuration code zero to four
// - Hardware revision letter as ten-based number
// - Record seconds count from first January 1994
`timescale 1ns/10ps
`default_nettype none
module drsm_directory #(
  parameter logic [3:0] FW_MAJOR = 4'h1,
  parameter logic [3:0] FW_MINOR = 4'h0,
  parameter logic [3:0] HW_REV = 4'h0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Bus request
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  output logic req_ready,
  // Bus answer
  output logic rsp_valid,
  output logic [15:0] rsp_word,
  output logic rsp_last,
  output logic rsp_exc,
  output logic [7:0] rsp_exc_code,
  // Record capture
  input wire logic rec_valid,
  input wire drsm_pkg::drsm_rec_in_t rec_in,
  output logic rec_ready,
  output logic rec_err,
  // Acknowledge from the relay
  input wire logic ack_valid,
  input wire logic [15:0] ack_number,
  // Raw status for the format words
  input wire logic [5:0] logic_inputs,
  input wire logic [11:0] cur_prot_disabled,
  input wire logic [8:0] func_disabled,
  input wire logic [2:0] prot_config,
  input wire logic [15:0] text_chars,
  output drsm_pkg::drsm_fmt_t fmt_words
);

  // ***********************************
  // State
  // ***********************************
  drsm_pkg::drsm_state_t state_q, state_d;
  logic [5:0] idx_q, idx_d;
  drsm_pkg::drsm_rec_t store_q [drsm_pkg::ENTRIES];
  drsm_pkg::drsm_rec_t store_d [drsm_pkg::ENTRIES];
  logic [2:0] wr_ptr_q, wr_ptr_d;
  logic [2:0] count_q, count_d;
  logic req_ready_q, req_ready_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [15:0] rsp_word_q, rsp_word_d;
  logic rsp_last_q, rsp_last_d;
  logic rsp_exc_q, rsp_exc_d;
  logic [7:0] rsp_exc_code_q, rsp_exc_code_d;
  logic rec_ready_q, rec_ready_d;
  logic rec_err_q, rec_err_d;
  drsm_pkg::drsm_fmt_t fmt_q, fmt_d;

  // ***********************************
  // Helpers
  // ***********************************
  function automatic logic [2:0] slot_add(input logic [2:0] a, input logic [2:0] b);
    logic [3:0] s;
    s = {1'b0, a} + {1'b0, b};
    slot_add = (s >= {1'b0, drsm_pkg::ENTRIES_W}) ? 3'(s - {1'b0, drsm_pkg::ENTRIES_W}) : s[2:0];
  endfunction : slot_add

  // Word at position idx of the page, idx 0 being word one
  function automatic logic [15:0] page_word(input logic [5:0] idx);
    logic [5:0] off;
    logic [2:0] ent;
    logic [2:0] fld;
    drsm_pkg::drsm_rec_t r;
    page_word = 16'h0000;
    off = idx - 6'h01;
    ent = 3'(off / {3'h0, drsm_pkg::ENTRY_WORDS_W});
    fld = 3'(off % {3'h0, drsm_pkg::ENTRY_WORDS_W});
    r = store_q[slot_add((count_q == drsm_pkg::ENTRIES_W) ? wr_ptr_q : 3'h0, ent)];
    if (idx == 6'h00)
    begin
      page_word = {13'h0000, count_q};
    end
    else if (ent < count_q)
    begin
      unique case (fld)
        3'h0: page_word = r.number;
        3'h1: page_word = r.seconds[31:16];
        3'h2: page_word = r.seconds[15:0];
        3'h3: page_word = r.millis[31:16];
        3'h4: page_word = r.millis[15:0];
        3'h5: page_word = r.origin;
        default: page_word = r.ack;
      endcase
    end
  endfunction : page_word

  // ***********************************
  // Request handling
  // ***********************************
  always_comb
  begin
    state_d = state_q;
    idx_d = idx_q;
    req_ready_d = req_ready_q;
    rsp_valid_d = 1'b0;
    rsp_word_d = rsp_word_q;
    rsp_last_d = 1'b0;
    rsp_exc_d = 1'b0;
    rsp_exc_code_d = rsp_exc_code_q;
    unique case (state_q)
      drsm_pkg::ST_IDLE:
      begin
        if (req_valid && req_ready_q)
        begin
          req_ready_d = 1'b0;
          if (req_func != drsm_pkg::FUNC_READ_HOLD)
          begin
            state_d = drsm_pkg::ST_EXC;
            rsp_exc_code_d = drsm_pkg::EXC_ILLEGAL_FUNC;
          end
          else if (req_addr != drsm_pkg::DIR_ADDR)
          begin
            state_d = drsm_pkg::ST_EXC;
            rsp_exc_code_d = drsm_pkg::EXC_ILLEGAL_ADDR;
          end
          else
          begin
            state_d = drsm_pkg::ST_STREAM;
            idx_d = 6'h00;
          end
        end
      end
      drsm_pkg::ST_STREAM:
      begin
        rsp_valid_d = 1'b1;
        rsp_word_d = page_word(idx_q);
        idx_d = idx_q + 6'h01;
        if (idx_q == drsm_pkg::LAST_WORD)
        begin
          rsp_last_d = 1'b1;
          state_d = drsm_pkg::ST_IDLE;
          req_ready_d = 1'b1;
        end
      end
      drsm_pkg::ST_EXC:
      begin
        rsp_valid_d = 1'b1;
        rsp_exc_d = 1'b1;
        rsp_last_d = 1'b1;
        rsp_word_d = 16'h0000;
        state_d = drsm_pkg::ST_IDLE;
        req_ready_d = 1'b1;
      end
      default:
      begin
        state_d = drsm_pkg::ST_IDLE;
        req_ready_d = 1'b1;
      end
    endcase
  end

  // ***********************************
  // Record store
  // ***********************************
  // Capture stalls while a page streams, so no record is added mid-answer; acknowledges still update ack words
  always_comb
  begin
    logic [31:0] secs;
    secs = 32'h0000_0000;
    store_d = store_q;
    wr_ptr_d = wr_ptr_q;
    count_d = count_q;
    rec_err_d = 1'b0;
    rec_ready_d = (state_d == drsm_pkg::ST_IDLE);
    if (ack_valid)
    begin
      for (int i = 0; i < drsm_pkg::ENTRIES; i++)
      begin
        if (store_q[i].number == ack_number && 3'(i) < count_q)
        begin
          store_d[i].ack = drsm_pkg::ACK_SET;
        end
      end
    end
    if (rec_valid && rec_ready_q)
    begin
      if (rec_in.cause < drsm_pkg::ORIGIN_MIN || rec_in.cause > drsm_pkg::ORIGIN_MAX)
      begin
        rec_err_d = 1'b1;
      end
      else
      begin
        // Times before 1994 clamp to zero rather than wrap
        secs = (rec_in.unix_s > drsm_pkg::EPOCH_1994_S) ?
          rec_in.unix_s - drsm_pkg::EPOCH_1994_S : 32'h0000_0000;
        store_d[wr_ptr_q].seconds = secs;
        store_d[wr_ptr_q].millis = rec_in.millis;
        store_d[wr_ptr_q].number = (rec_in.number < drsm_pkg::NUM_MIN) ?
          drsm_pkg::NUM_MIN : rec_in.number;
        store_d[wr_ptr_q].origin = {13'h0000, rec_in.cause};
        store_d[wr_ptr_q].ack = 16'h0000;
        wr_ptr_d = slot_add(wr_ptr_q, 3'h1);
        if (count_q != drsm_pkg::ENTRIES_W)
        begin
          count_d = count_q + 3'h1;
        end
      end
    end
  end

  // ***********************************
  // Format words
  // ***********************************
  always_comb
  begin
    fmt_d.input_status = {10'h000, logic_inputs} & drsm_pkg::INPUT_MASK;
    fmt_d.current_prot_disable = {4'h0, cur_prot_disabled} & drsm_pkg::CUR_DIS_MASK;
    fmt_d.function_disable = {7'h00, func_disabled} & drsm_pkg::FUNC_DIS_MASK;
    fmt_d.firmware_version = 16'({12'h000, FW_MAJOR} * drsm_pkg::VER_DIGIT_SCALE)
      + {12'h000, FW_MINOR};
    fmt_d.hardware_version = drsm_pkg::VER_LETTER_BASE + {12'h000, HW_REV};
    // Out-of-range codes read as disabled, the safe reading
    fmt_d.prot_configuration = ({13'h0000, prot_config} > drsm_pkg::CONFIG_MAX) ?
      16'h0000 : {13'h0000, prot_config};
    fmt_d.char_pair = {drsm_pkg::drsm_char(text_chars[15:8]),
      drsm_pkg::drsm_char(text_chars[7:0])};
  end

  // ***********************************
  // Registers
  // ***********************************
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state_q <= drsm_pkg::ST_IDLE;
      idx_q <= 6'h00;
      wr_ptr_q <= 3'h0;
      count_q <= 3'h0;
      req_ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_word_q <= 16'h0000;
      rsp_last_q <= 1'b0;
      rsp_exc_q <= 1'b0;
      rsp_exc_code_q <= 8'h00;
      rec_ready_q <= 1'b1;
      rec_err_q <= 1'b0;
      fmt_q <= '0;
      store_q <= '{default: '0};
    end
    else
    begin
      state_q <= state_d;
      idx_q <= idx_d;
      wr_ptr_q <= wr_ptr_d;
      count_q <= count_d;
      req_ready_q <= req_ready_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_word_q <= rsp_word_d;
      rsp_last_q <= rsp_last_d;
      rsp_exc_q <= rsp_exc_d;
      rsp_exc_code_q <= rsp_exc_code_d;
      rec_ready_q <= rec_ready_d;
      rec_err_q <= rec_err_d;
      fmt_q <= fmt_d;
      store_q <= store_d;
    end
  end

  assign req_ready = req_ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_word = rsp_word_q;
  assign rsp_last = rsp_last_q;
  assign rsp_exc = rsp_exc_q;
  assign rsp_exc_code = rsp_exc_code_q;
  assign rec_ready = rec_ready_q;
  assign rec_err = rec_err_q;
  assign fmt_words = fmt_q;

endmodule : drsm_directory
`default_nettype wire

// ---- tb/drsm_directory_props.sv ----
// Port checker for the directory page.
// Assumes it is bound onto drsm_directory, one clock.
`timescale 1ns/10ps
`default_nettype none
module drsm_directory_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Bus
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_word,
  input wire logic rsp_last,
  input wire logic rsp_exc,
  input wire logic [7:0] rsp_exc_code,
  // Records and formats
  input wire logic rec_valid,
  input wire drsm_pkg::drsm_rec_in_t rec_in,
  input wire logic rec_ready,
  input wire logic rec_err,
  input wire logic [5:0] logic_inputs,
  input wire drsm_pkg::drsm_fmt_t fmt_words
);
  // ****
  // Properties
  // ****
  logic take;
  logic rd;
  logic bad;
  logic rd_dir;
  logic bad_fn;
  logic bad_ad;
  logic res_ok;
  assign take = req_valid && req_ready;
  assign rd = req_func == drsm_pkg::FUNC_READ_HOLD;
  assign bad = rec_in.cause < drsm_pkg::ORIGIN_MIN || rec_in.cause > drsm_pkg::ORIGIN_MAX;
  assign rd_dir = take && rd && req_addr == drsm_pkg::DIR_ADDR;
  assign bad_fn = take && !rd;
  assign bad_ad = take && rd && req_addr != drsm_pkg::DIR_ADDR;
  assign res_ok = fmt_words.current_prot_disable[15:12] == 4'h0
    && fmt_words.function_disable[15:9] == 7'h00 && fmt_words.prot_configuration <= 16'h0004;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_exc(logic [7:0] code);
    ##2 (rsp_valid && rsp_exc && rsp_last && rsp_exc_code == code && rsp_word == 16'h0000);
  endsequence
  sequence s_first;
    !req_ready ##1 (rsp_valid && !rsp_exc && rsp_word <= 16'h0005);
  endsequence
  // Word 36 shows one edge after the 36th streaming edge
  sequence s_done;
    ##37 (rsp_valid && rsp_last && req_ready);
  endsequence
  sequence s_inputs;
    fmt_words.input_status == {10'h000, $past(logic_inputs)};
  endsequence
  a_read_start: assert property (rd_dir |=> s_first)
    else $error("directory answer did not start with a count");
  a_read_end: assert property (rd_dir |-> s_done)
    else $error("directory answer length wrong");
  a_bad_func: assert property (bad_fn |-> s_exc(drsm_pkg::EXC_ILLEGAL_FUNC))
    else $error("wrong function not refused");
  a_bad_addr: assert property (bad_ad |-> s_exc(drsm_pkg::EXC_ILLEGAL_ADDR))
    else $error("wrong address not refused");
  a_stream_busy: assert property (rsp_valid && !rsp_last |-> !req_ready && !rec_ready)
    else $error("ready high in mid answer");
  a_rec_bad: assert property (rec_valid && rec_ready && bad |=> rec_err)
    else $error("bad origin not flagged");
  a_rec_good: assert property (rec_valid && rec_ready && !bad |=> !rec_err)
    else $error("good origin flagged");
  a_input_bits: assert property ($past(resetn) |-> s_inputs)
    else $error("input status word wrong");
  a_reserved_zero: assert property (res_ok)
    else $error("reserved bits or code out of range");
endmodule : drsm_directory_props
bind drsm_directory drsm_directory_props drsm_directory_props_i (.core_clk, .resetn, .req_valid,
  .req_func, .req_addr, .req_ready, .rsp_valid, .rsp_word, .rsp_last, .rsp_exc, .rsp_exc_code,
  .rec_valid, .rec_in, .rec_ready, .rec_err, .logic_inputs, .fmt_words);
`default_nettype wire

// ---- tb/drsm_bus_master.sv ----
// Serial-bus master model issuing requests with the commanded function and address.
// Assumes the bench pulses go for one cycle with the command set.
`timescale 1ns/10ps
`default_nettype none
module drsm_bus_master (
  // Clock and command
  input wire logic core_clk,
  input wire logic go,
  input wire logic [7:0] func,
  input wire logic [15:0] addr,
  input wire logic [3:0] gap,
  // Request
  output logic req_valid,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  input wire logic req_ready
);
  initial
  begin
    req_valid = 1'b0;
    req_func = 8'h55;
    req_addr = 16'haaaa;
    forever
    begin
      @(negedge core_clk);
      if (go)
      begin
        // Slow master: idle gap first
        repeat (gap) @(negedge core_clk);
        req_valid = 1'b1;
        req_func = func;
        req_addr = addr;
        // Ready is judged once settled, then the next edge takes the request
        while (req_ready !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        @(negedge core_clk);
        req_valid = 1'b0;
        // Released lines no longer hold the old value
        req_func = ~req_func;
        req_addr = ~req_addr;
      end
    end
  end
endmodule : drsm_bus_master
`default_nettype wire

// ---- tb/drsm_directory_tb_top.sv ----
// Bench for the directory page.
// Assumes drsm_bus_master and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module drsm_directory_tb_top;
  logic core_clk = 0;
  logic resetn = 0;
  logic go = 0;
  logic [7:0] cmd_f = 0;
  logic [15:0] cmd_a = 0;
  logic [3:0] cmd_g = 0;
  logic req_valid, req_ready, rsp_valid, rsp_last, rsp_exc, rec_ready, rec_err;
  logic [7:0] req_func, rsp_exc_code;
  logic [15:0] req_addr, rsp_word;
  logic rec_valid = 0;
  logic ack_valid = 0;
  logic [15:0] ack_number = 0;
  logic [15:0] text_chars = 0;
  logic [5:0] logic_inputs = 0;
  logic [11:0] cur_prot_disabled = 0;
  logic [8:0] func_disabled = 0;
  logic [2:0] prot_config = 0;
  drsm_pkg::drsm_rec_in_t rec_in = '0;
  drsm_pkg::drsm_fmt_t fmt_words;
  drsm_pkg::drsm_rec_t q[$];
  int err_total = 0;
  int checked = 0;
  always #50 core_clk = ~core_clk;
  drsm_directory drsm_directory_i (.core_clk, .resetn, .req_valid, .req_func, .req_addr,
    .req_ready, .rsp_valid, .rsp_word, .rsp_last, .rsp_exc, .rsp_exc_code, .rec_valid, .rec_in,
    .rec_ready, .rec_err, .ack_valid, .ack_number, .logic_inputs, .cur_prot_disabled,
    .func_disabled, .prot_config, .text_chars, .fmt_words);
  drsm_bus_master drsm_bus_master_i (.core_clk, .go, .func(cmd_f), .addr(cmd_a), .gap(cmd_g),
    .req_valid, .req_func, .req_addr, .req_ready);
  // ****
  // Helpers
  // ****
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  function automatic logic [7:0] pc(logic [7:0] c);
    return (c >= 8'h20 && c <= 8'h7f) ? c : 8'h20;
  endfunction : pc
  function automatic logic [15:0] cfg_exp(logic [2:0] p);
    return (p > 3'h4) ? 16'h0000 : {13'h0000, p};
  endfunction : cfg_exp
  // Entry words follow the record struct, high half first
  function automatic logic [15:0] exp_word(int i);
    logic [111:0] r;
    if (i == 1)
      return 16'(q.size());
    if ((i - 2) / 7 >= q.size())
      return 16'h0000;
    r = q[(i - 2) / 7];
    return r[111 - 16 * ((i - 2) % 7) -: 16];
  endfunction : exp_word
  task automatic page(logic [7:0] f, logic [15:0] a, logic [3:0] g);
    int n;
    int t;
    logic ok;
    logic [7:0] ec;
    n = 0;
    t = 0;
    ok = f == 8'h03 && a == drsm_pkg::DIR_ADDR;
    ec = (f == 8'h03) ? drsm_pkg::EXC_ILLEGAL_ADDR : drsm_pkg::EXC_ILLEGAL_FUNC;
    @(negedge core_clk);
    {cmd_f, cmd_a, cmd_g, go} <= {f, a, g, 1'b1};
    @(negedge core_clk);
    go <= 1'b0;
    do
    begin
      @(negedge core_clk);
      t++;
      if (rsp_valid === 1'b1)
      begin
        n++;
        if (ok)
          chk("word", {rsp_exc, rsp_last, rsp_word}, {1'b0, n == 36, exp_word(n)});
        else
          chk("exc", {rsp_exc, rsp_last, rsp_exc_code, rsp_word}, {2'b11, ec, 16'h0});
      end
    end
    while (t < 80 && rsp_last !== 1'b1);
    chk("beats", n, ok ? 36 : 1);
  endtask : page
  task automatic rec(int i);
    drsm_pkg::drsm_rec_t m;
    logic [2:0] c;
    c = (i == 4) ? 3'h0 : (i == 6) ? 3'h5 : 3'($urandom_range(1, 4));
    m.number = (i == 2) ? 16'h0000 : 16'($urandom);
    m.seconds = (i == 1) ? 32'h0000_1000 : $urandom;
    m.millis = $urandom;
    @(negedge core_clk);
    rec_valid <= 1'b1;
    rec_in <= {m.number, m.seconds, m.millis, c};
    while (rec_ready !== 1'b1) @(negedge core_clk);
    if (c >= 3'h1 && c <= 3'h4)
    begin
      m.number = (m.number == 16'h0000) ? 16'h0001 : m.number;
      m.seconds = (m.seconds < drsm_pkg::EPOCH_1994_S) ? 32'h0 :
        m.seconds - drsm_pkg::EPOCH_1994_S;
      m.origin = {13'h0, c};
      m.ack = 16'h0000;
      q.push_back(m);
      if (q.size() > 5)
        q.pop_front();
    end
  endtask : rec
  // ****
  // Tests
  // ****
  initial
  begin
    void'($urandom(32'h7dec));
    repeat (5) @(negedge core_clk);
    resetn <= 1'b1;
    page(8'h03, 16'h3d00, 4'h0);
    page(8'h10, 16'h3d00, 4'h0);
    page(8'h03, 16'h3d01, 4'h2);
    for (int i = 0; i < 8; i++)
      rec(i);
    @(negedge core_clk);
    rec_valid <= 1'b0;
    ack_valid <= 1'b1;
    ack_number <= q[1].number;
    foreach (q[j])
      if (q[j].number == q[1].number)
        q[j].ack = 16'h0001;
    @(negedge core_clk);
    ack_valid <= 1'b0;
    page(8'h06, 16'h3d00, 4'h1);
    page(8'h03, 16'h3d00, 4'h3);
    repeat (20)
    begin
      @(negedge core_clk);
      chk("inputs", fmt_words.input_status, {10'h0, logic_inputs});
      chk("curdis", fmt_words.current_prot_disable, {4'h0, cur_prot_disabled});
      chk("fndis", fmt_words.function_disable, {7'h0, func_disabled});
      chk("fw", fmt_words.firmware_version, 16'h000a);
      chk("hw", fmt_words.hardware_version, 16'h000a);
      chk("cfg", fmt_words.prot_configuration, cfg_exp(prot_config));
      chk("text", fmt_words.char_pair, {pc(text_chars[15:8]), pc(text_chars[7:0])});
      {logic_inputs, cur_prot_disabled, func_disabled, prot_config, text_chars} <=
        46'({$urandom, $urandom});
    end
    end_sim();
  end
  // Over twenty times the expected run
  initial
  begin
    #300_000;
    err_total++;
    end_sim();
  end
endmodule : drsm_directory_tb_top
`default_nettype wire
